/* src/ofb_bridge.sv */
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module ofb_bridge #(
    parameter logic [1:0] MODE = ofb_pkg::OFB_MODE_MM_ST,
    parameter bit BACKPRESSURE = 1'b1,
    parameter bit PACKET_EN = 1'b1,
    parameter bit DUAL_CLOCK = 1'b0,
    parameter int DEPTH = ofb_pkg::OFB_DEPTH,
    parameter int DATA_W = ofb_pkg::OFB_WORD_W,
    parameter int BITS_PER_SYM = ofb_pkg::OFB_BITS_PER_SYM,
    parameter int SYMS_PER_BEAT = ofb_pkg::OFB_SYMS_PER_BEAT,
    parameter int CHAN_W = ofb_pkg::OFB_CHAN_W,
    parameter int ERR_W = ofb_pkg::OFB_ERR_W
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic wr_write_i,
    input wire logic wr_address_i,
    input wire logic [DATA_W-1:0] wr_writedata_i,
    output logic wr_waitrequest_o,
    input wire logic rd_read_i,
    input wire logic rd_address_i,
    output logic [DATA_W-1:0] rd_readdata_o,
    output logic rd_waitrequest_o,
    input wire logic snk_valid_i,
    output logic snk_ready_o,
    input wire logic [DATA_W-1:0] snk_data_i,
    input wire logic snk_packet_start_flag_i,
    input wire logic snk_packet_end_flag_i,
    input wire logic [ofb_pkg::OFB_EMPTY_W-1:0] snk_empty_i,
    input wire logic [CHAN_W-1:0] snk_channel_i,
    input wire logic [ERR_W-1:0] snk_error_i,
    input wire logic src_ready_i,
    output logic src_valid_o,
    output logic [DATA_W-1:0] src_data_o,
    output logic src_packet_start_flag_o,
    output logic src_packet_end_flag_o,
    output logic [ofb_pkg::OFB_EMPTY_W-1:0] src_empty_o,
    output logic [CHAN_W-1:0] src_channel_o,
    output logic [ERR_W-1:0] src_error_o,
    output logic [$clog2(DEPTH+1)-1:0] wr_status_level_o,
    output logic wr_status_full_o,
    output logic [$clog2(DEPTH+1)-1:0] rd_status_level_o,
    output logic rd_status_empty_o
);
    //////////////////////////////////////////////////////////////////////////
    localparam int EW = ofb_pkg::OFB_EMPTY_W;
    localparam int SBW = 2 + EW + CHAN_W + ERR_W;
    localparam int FW = DATA_W + SBW;
    localparam int CW = $clog2(DEPTH+1);
    localparam int USABLE = DUAL_CLOCK ?
        DEPTH - ofb_pkg::OFB_DC_MARGIN : DEPTH;
    localparam bit IN_MM = (MODE == ofb_pkg::OFB_MODE_MM_MM) ||
        (MODE == ofb_pkg::OFB_MODE_MM_ST);
    localparam bit OUT_MM = (MODE == ofb_pkg::OFB_MODE_MM_MM) ||
        (MODE == ofb_pkg::OFB_MODE_ST_MM);
    localparam bit MIXED = (IN_MM != OUT_MM);
    localparam bit SB_EN = PACKET_EN && MIXED;

    typedef enum logic [1:0]
    {
        OFB_SRC_IDLE = 2'b00,
        OFB_SRC_SHOW = 2'b01
    } ofb_src_state_e;

    logic [SBW-1:0] wr_sideband;
    logic [SBW-1:0] rd_sideband;
    logic [SBW-1:0] snk_sideband;
    logic [FW-1:0] fifo_in;
    logic [FW-1:0] fifo_out;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [CW-1:0] level;
    logic mm_push;
    logic mm_pop;
    logic src_fire;
    logic wr_sb_load;
    ofb_src_state_e src_state;
    ofb_src_state_e next_src_state;

    //////////////////////////////////////////////////////////////////////////
    // Packs the word-1 fields into the MM layout.
    function automatic logic [31:0] ofb_pack_sb(input logic [SBW-1:0] sb);
        logic [31:0] w;
        w = ofb_pkg::OFB_SIDEBAND_RESET;
        w[ofb_pkg::OFB_START_BIT] = sb[0];
        w[ofb_pkg::OFB_END_BIT] = sb[1];
        w[ofb_pkg::OFB_EMPTY_LSB +: EW] = sb[2 +: EW];
        w[ofb_pkg::OFB_CHAN_LSB +: CHAN_W] = sb[2+EW +: CHAN_W];
        w[ofb_pkg::OFB_ERR_LSB +: ERR_W] = sb[2+EW+CHAN_W +: ERR_W];
        ofb_pack_sb = w;
    endfunction

    // Extracts the word-1 fields from the MM layout.
    function automatic logic [SBW-1:0] ofb_unpack_sb(input logic [31:0] w);
        ofb_unpack_sb = {w[ofb_pkg::OFB_ERR_LSB +: ERR_W],
            w[ofb_pkg::OFB_CHAN_LSB +: CHAN_W],
            w[ofb_pkg::OFB_EMPTY_LSB +: EW],
            w[ofb_pkg::OFB_END_BIT], w[ofb_pkg::OFB_START_BIT]};
    endfunction

    // Reverses symbol order between MM word and stream beat.
    function automatic logic [DATA_W-1:0] ofb_swap(input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        r = d;
        for (int i = 0; i < SYMS_PER_BEAT; i++)
        begin
            r[i*BITS_PER_SYM +: BITS_PER_SYM] =
                d[(SYMS_PER_BEAT-1-i)*BITS_PER_SYM +: BITS_PER_SYM];
        end
        ofb_swap = r;
    endfunction

    // Tells whether an access reaches the data word rather than the sideband.
    function automatic logic ofb_is_data(input logic addr);
        ofb_is_data = !SB_EN || (addr == ofb_pkg::OFB_ADDR_DATA);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Write side.
    assign snk_sideband = {snk_error_i, snk_channel_i, snk_empty_i,
        snk_packet_end_flag_i, snk_packet_start_flag_i};
    assign mm_push = wr_write_i && ofb_is_data(wr_address_i);
    assign wr_sb_load = SB_EN && IN_MM && wr_write_i &&
        !ofb_is_data(wr_address_i);

    // Stream beats are stored in stream order; in mixed modes the MM side, write or read, swaps once.
    always_comb
    begin
        if (IN_MM)
        begin
            fifo_in_valid = mm_push;
            fifo_in = {(SB_EN ? wr_sideband : SBW'(0)),
                (MIXED ? ofb_swap(wr_writedata_i) :
                wr_writedata_i)};
        end
        else
        begin
            fifo_in_valid = snk_valid_i;
            fifo_in = {(PACKET_EN ? snk_sideband : SBW'(0)),
                snk_data_i};
        end
    end

    assign wr_waitrequest_o = IN_MM && BACKPRESSURE && mm_push &&
        !fifo_in_ready;
    assign snk_ready_o = IN_MM ? 1'b0 :
        (BACKPRESSURE ? fifo_in_ready : 1'b1);

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            wr_sideband <= '0;
        end
        else if (wr_sb_load)
        begin
            wr_sideband <= ofb_unpack_sb(32'(wr_writedata_i));
        end
    end

    //////////////////////////////////////////////////////////////////////////
    ofb_fifo #(
        .WIDTH(FW),
        .DEPTH(DEPTH),
        .USABLE(USABLE)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out),
        .level_o(level)
    );

    //////////////////////////////////////////////////////////////////////////
    // Memory-mapped read side.
    assign mm_pop = OUT_MM && rd_read_i && fifo_out_valid &&
        ofb_is_data(rd_address_i);
    assign rd_waitrequest_o = OUT_MM && BACKPRESSURE && rd_read_i &&
        !fifo_out_valid && ofb_is_data(rd_address_i);

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            rd_readdata_o <= '0;
        end
        else if (OUT_MM && rd_read_i)
        begin
            if (SB_EN && rd_address_i == ofb_pkg::OFB_ADDR_SIDEBAND)
            begin
                rd_readdata_o <= DATA_W'(ofb_pack_sb(rd_sideband));
            end
            else if (fifo_out_valid)
            begin
                rd_readdata_o <= MIXED ? ofb_swap(fifo_out[DATA_W-1:0]) :
                    fifo_out[DATA_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            rd_sideband <= '0;
        end
        else if (mm_pop && SB_EN)
        begin
            rd_sideband <= fifo_out[FW-1:DATA_W];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Streaming source: ready seen in one cycle, data shown the next.
    assign src_fire = !OUT_MM && fifo_out_valid &&
        (src_ready_i || !BACKPRESSURE);
    assign fifo_out_ready = OUT_MM ? mm_pop : src_fire;

    always_comb
    begin
        next_src_state = src_state;
        case (src_state)
            OFB_SRC_IDLE:
            begin
                if (src_fire)
                begin
                    next_src_state = OFB_SRC_SHOW;
                end
            end
            OFB_SRC_SHOW:
            begin
                if (!src_fire)
                begin
                    next_src_state = OFB_SRC_IDLE;
                end
            end
            default:
            begin
                next_src_state = OFB_SRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            src_state <= OFB_SRC_IDLE;
        end
        else
        begin
            src_state <= next_src_state;
        end
    end

    assign src_valid_o = (src_state == OFB_SRC_SHOW);

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            src_data_o <= '0;
        end
        else if (src_fire)
        begin
            src_data_o <= fifo_out[DATA_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            {src_error_o, src_channel_o, src_empty_o,
             src_packet_end_flag_o, src_packet_start_flag_o} <= '0;
        end
        else if (src_fire)
        begin
            {src_error_o, src_channel_o, src_empty_o,
             src_packet_end_flag_o, src_packet_start_flag_o} <=
                fifo_out[FW-1:DATA_W];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Status ports share the single clock domain.
    assign wr_status_level_o = level;
    assign wr_status_full_o = !fifo_in_ready;
    assign rd_status_level_o = level;
    assign rd_status_empty_o = !fifo_out_valid;
endmodule
`default_nettype wire

/* src/ofb_pkg.sv */
`default_nettype none
package ofb_pkg;
    localparam int OFB_DEPTH = 32;
    localparam int OFB_WORD_W = 32;
    localparam int OFB_BITS_PER_SYM = 8;
    localparam int OFB_SYMS_PER_BEAT = 4;
    localparam int OFB_CHAN_W = 8;
    localparam int OFB_ERR_W = 8;
    localparam int OFB_EMPTY_W = 5;
    localparam logic OFB_ADDR_DATA = 1'b0;
    localparam logic OFB_ADDR_SIDEBAND = 1'b1;
    localparam int OFB_START_BIT = 0;
    localparam int OFB_END_BIT = 1;
    localparam int OFB_EMPTY_LSB = 2;
    localparam int OFB_CHAN_LSB = 8;
    localparam int OFB_ERR_LSB = 16;
    localparam int OFB_DC_MARGIN = 3;
    localparam logic [31:0] OFB_SIDEBAND_RESET = 32'h0000_0000;
    localparam logic [1:0] OFB_MODE_MM_MM = 2'b00;
    localparam logic [1:0] OFB_MODE_ST_ST = 2'b01;
    localparam logic [1:0] OFB_MODE_MM_ST = 2'b10;
    localparam logic [1:0] OFB_MODE_ST_MM = 2'b11;
endpackage
`default_nettype wire

/* src/ofb_fifo.sv */
`default_nettype none
module ofb_fifo #(
    parameter int WIDTH = 56,
    parameter int DEPTH = 32,
    parameter int USABLE = 32
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] level_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] LIMIT = CW'(USABLE);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] ofb_next_ptr(input logic [AW-1:0] p);
        ofb_next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready_o = (count < LIMIT);
    assign out_valid_o = (count != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr];
    assign level_o = count;

    always_ff @(posedge sys_clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= ofb_next_ptr(wr_ptr);
            end
            if (pop)
            begin
                rd_ptr <= ofb_next_ptr(rd_ptr);
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/ofb_bridge_props.sv */
`default_nettype none
module ofb_chk #(
    parameter int DEPTH = 32,
    parameter logic [1:0] MODE = ofb_pkg::OFB_MODE_MM_ST
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic wr_write_i,
    input wire logic wr_address_i,
    input wire logic wr_waitrequest_o,
    input wire logic src_ready_i,
    input wire logic src_valid_o,
    input wire logic snk_ready_o,
    input wire logic [$clog2(DEPTH+1)-1:0] wr_status_level_o,
    input wire logic wr_status_full_o,
    input wire logic [$clog2(DEPTH+1)-1:0] rd_status_level_o,
    input wire logic rd_status_empty_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam bit IN_MM = (MODE == ofb_pkg::OFB_MODE_MM_MM) ||
        (MODE == ofb_pkg::OFB_MODE_MM_ST);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    property p_valid_lat;
        src_valid_o |-> $past(src_ready_i);
    endproperty
    a_valid_lat: assert property (p_valid_lat)
        else $error("source valid without ready a cycle before");
    property p_full_wait;
        wr_write_i && !wr_address_i && wr_status_full_o |-> wr_waitrequest_o;
    endproperty
    a_full_wait: assert property (p_full_wait)
        else $error("write taken while full");
    property p_room_go;
        wr_write_i && !wr_address_i && !wr_status_full_o |-> !wr_waitrequest_o;
    endproperty
    a_room_go: assert property (p_room_go)
        else $error("write held off with room left");
    property p_full_lvl;
        wr_status_full_o == (wr_status_level_o == DEPTH);
    endproperty
    a_full_lvl: assert property (p_full_lvl)
        else $error("full flag disagrees with level");
    property p_empty_lvl;
        rd_status_empty_o == (rd_status_level_o == 0);
    endproperty
    a_empty_lvl: assert property (p_empty_lvl)
        else $error("empty flag disagrees with level");
    property p_lvl_same;
        wr_status_level_o == rd_status_level_o;
    endproperty
    a_lvl_same: assert property (p_lvl_same)
        else $error("status levels differ");
    property p_reset;
        $rose(rstn_i) |-> !src_valid_o && rd_status_empty_o;
    endproperty
    a_reset: assert property (p_reset)
        else $error("state not cleared by reset");
    property p_mm_in;
        snk_ready_o == (!IN_MM && !wr_status_full_o);
    endproperty
    a_mm_in: assert property (p_mm_in)
        else $error("sink ready disagrees with mode and room");
endmodule
bind ofb_bridge ofb_chk #(.DEPTH(DEPTH), .MODE(MODE)) u_chk (
    .sys_clk_i, .rstn_i, .wr_write_i, .wr_address_i, .wr_waitrequest_o,
    .src_ready_i, .src_valid_o, .snk_ready_o, .wr_status_level_o,
    .wr_status_full_o, .rd_status_level_o, .rd_status_empty_o
);
`default_nettype wire

/* sim/ofb_sink_model.sv */
`default_nettype none
module ofb_sink_model (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic stall_i,
    output var logic ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Ready is offered at random, or held low while stalled.
    initial
    begin
        ready_o = 1'b0;
        forever
        begin
            @(negedge sys_clk_i);
            ready_o = rstn_i && !stall_i && ($urandom_range(3) != 0);
        end
    end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LW = $clog2(ofb_pkg::OFB_DEPTH + 1);
    logic sys_clk_i, rstn_i, wr_write_i, wr_address_i, rd_read_i;
    logic rd_address_i, snk_valid_i, snk_packet_start_flag_i;
    logic snk_packet_end_flag_i, stall;
    logic [31:0] wr_writedata_i, snk_data_i, sb;
    logic [ofb_pkg::OFB_EMPTY_W-1:0] snk_empty_i;
    logic [7:0] snk_channel_i, snk_error_i;
    logic [63:0] noise;
    logic [LW-1:0] lvl;
    logic [54:0] expq[$];
    int errors, total_checks, w, n;
    logic r_read, r_addr, s_valid, took;
    logic [31:0] s_data, s_sb, sd[8], ss[8];
    logic [31:0] rdq[$];
    wire logic s_ready, r_wait;
    wire logic [31:0] r_data;
    wire logic src_ready_i, wr_waitrequest_o, rd_waitrequest_o, snk_ready_o;
    wire logic src_valid_o, src_packet_start_flag_o, src_packet_end_flag_o;
    wire logic wr_status_full_o, rd_status_empty_o;
    wire logic [31:0] rd_readdata_o, src_data_o;
    wire logic [ofb_pkg::OFB_EMPTY_W-1:0] src_empty_o;
    wire logic [7:0] src_channel_o, src_error_o;
    wire logic [LW-1:0] wr_status_level_o, rd_status_level_o;
    ofb_bridge #(.MODE(ofb_pkg::OFB_MODE_MM_ST)) uut (
        .sys_clk_i, .rstn_i, .wr_write_i, .wr_address_i, .wr_writedata_i,
        .wr_waitrequest_o, .rd_read_i, .rd_address_i, .rd_readdata_o,
        .rd_waitrequest_o, .snk_valid_i, .snk_ready_o, .snk_data_i,
        .snk_packet_start_flag_i, .snk_packet_end_flag_i, .snk_empty_i,
        .snk_channel_i, .snk_error_i, .src_ready_i, .src_valid_o,
        .src_data_o, .src_packet_start_flag_o, .src_packet_end_flag_o,
        .src_empty_o, .src_channel_o, .src_error_o, .wr_status_level_o,
        .wr_status_full_o, .rd_status_level_o, .rd_status_empty_o
    );
    ofb_sink_model sink (.sys_clk_i, .rstn_i, .stall_i(stall),
        .ready_o(src_ready_i));
    ofb_bridge #(.MODE(ofb_pkg::OFB_MODE_ST_MM)) uut_rd (
        .sys_clk_i, .rstn_i, .wr_write_i(1'b0), .wr_address_i(1'b0),
        .wr_writedata_i(32'h0000_0000), .wr_waitrequest_o(),
        .rd_read_i(r_read), .rd_address_i(r_addr), .rd_readdata_o(r_data),
        .rd_waitrequest_o(r_wait), .snk_valid_i(s_valid),
        .snk_ready_o(s_ready), .snk_data_i(s_data),
        .snk_packet_start_flag_i(s_sb[0]), .snk_packet_end_flag_i(s_sb[1]),
        .snk_empty_i(s_sb[6:2]), .snk_channel_i(s_sb[15:8]),
        .snk_error_i(s_sb[23:16]), .src_ready_i(1'b0), .src_valid_o(),
        .src_data_o(), .src_packet_start_flag_o(), .src_packet_end_flag_o(),
        .src_empty_o(), .src_channel_o(), .src_error_o(),
        .wr_status_level_o(), .wr_status_full_o(), .rd_status_level_o(),
        .rd_status_empty_o()
    );
    //////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    initial
    begin
        noise = 64'h0000_0000_0000_0000;
        forever
        begin
            {rd_read_i, rd_address_i, snk_valid_i, snk_packet_start_flag_i,
                snk_packet_end_flag_i, snk_data_i, snk_empty_i,
                snk_channel_i, snk_error_i} = noise[57:0];
            @(negedge sys_clk_i);
            noise = {$urandom, $urandom};
        end
    end
    function automatic logic [54:0] beat(input logic [31:0] d);
        return {sb[23:16], sb[15:8], sb[6:2], sb[1], sb[0],
            d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction
    task automatic end_of_test();
        $display("errors=%0d checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic miss(input string m);
        errors++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) miss("status value mismatch");
    endtask
    task automatic chk_beat(input logic [54:0] e);
        total_checks++;
        if ({src_error_o, src_channel_o, src_empty_o, src_packet_end_flag_o,
            src_packet_start_flag_o, src_data_o} !== e) miss("beat mismatch");
    endtask
    task automatic chk_rd(input logic [31:0] e);
        total_checks++;
        if (r_data !== e) miss("read data mismatch");
    endtask
    task automatic mm_wr(input logic a, input logic [31:0] d);
        w = 0;
        @(negedge sys_clk_i);
        wr_write_i = 1'b1;
        wr_address_i = a;
        wr_writedata_i = d;
        @(posedge sys_clk_i);
        while (wr_waitrequest_o !== 1'b0)
        begin
            if (++w > 500) begin miss("write timeout"); end_of_test(); end
            @(posedge sys_clk_i);
        end
        if (a) sb = d;
        else expq.push_back(beat(d));
        #1;
    endtask
    task automatic wr_idle();
        @(negedge sys_clk_i);
        wr_write_i = 1'b0;
        r_read = 1'b0;
        s_valid = 1'b0;
    endtask
    task automatic mm_rd(input logic a, input logic [31:0] e);
        w = 0;
        @(negedge sys_clk_i);
        r_read = 1'b1;
        r_addr = a;
        @(posedge sys_clk_i);
        while (r_wait !== 1'b0)
        begin
            if (++w > 500) begin miss("read timeout"); end_of_test(); end
            @(posedge sys_clk_i);
        end
        rdq.push_back(e);
        #1;
    endtask
    task automatic st_wr(input logic [31:0] d, input logic [31:0] s);
        w = 0;
        @(negedge sys_clk_i);
        s_valid = 1'b1;
        s_data = d;
        s_sb = s;
        @(posedge sys_clk_i);
        while (s_ready !== 1'b1)
        begin
            if (++w > 500) begin miss("stream timeout"); end_of_test(); end
            @(posedge sys_clk_i);
        end
        #1;
    endtask
    task automatic drain();
        n = 0;
        while (expq.size() != 0 || src_valid_o !== 1'b0)
        begin
            if (++n > 2000) begin miss("drain timeout"); end_of_test(); end
            @(negedge sys_clk_i);
        end
    endtask
    always @(posedge sys_clk_i)
        if (rstn_i === 1'b1 && src_valid_o === 1'b1)
        begin
            if (expq.size() == 0) miss("unexpected beat");
            else chk_beat(expq.pop_front());
        end
    always @(posedge sys_clk_i)
    begin
        if (took)
        begin
            if (rdq.size() == 0) miss("unexpected read data");
            else chk_rd(rdq.pop_front());
        end
        took = rstn_i === 1'b1 && r_read === 1'b1 && r_wait === 1'b0;
    end
    //////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hed89_2d7d));
        {errors, total_checks, sb, stall, rstn_i} = '0;
        {wr_write_i, wr_address_i, wr_writedata_i} = '0;
        {r_read, r_addr, s_valid, s_data, s_sb} = '0;
        repeat (6) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        @(negedge sys_clk_i);
        chk_val(32'(src_valid_o), 32'h0000_0000);
        chk_val(32'(rd_status_empty_o), 32'h0000_0001);
        for (int i = 0; i < 60; i++)
        begin
            if ($urandom_range(2) == 0)
                mm_wr(1'b1, $urandom & 32'h00ff_ff7f);
            mm_wr(1'b0, $urandom);
        end
        wr_idle();
        drain();
        stall = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        lvl = wr_status_level_o;
        mm_wr(1'b1, 32'h0000_0003);
        wr_idle();
        chk_val(32'(wr_status_level_o), 32'(lvl));
        n = 0;
        while (wr_status_full_o !== 1'b1 && n++ < 40) mm_wr(1'b0, $urandom);
        chk_val(32'(wr_status_level_o), ofb_pkg::OFB_DEPTH);
        fork
            mm_wr(1'b0, 32'h1234_5678);
            begin
                repeat (6) @(negedge sys_clk_i);
                stall = 1'b0;
            end
        join
        chk_val(32'(w > 5), 32'h0000_0001);
        wr_idle();
        drain();
        stall = 1'b1;
        for (int i = 0; i < 3; i++) mm_wr(1'b0, $urandom);
        wr_idle();
        rstn_i = 1'b0;
        expq.delete();
        sb = 32'h0000_0000;
        repeat (2) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        @(negedge sys_clk_i);
        chk_val(32'(src_valid_o), 32'h0000_0000);
        chk_val(32'(wr_status_level_o), 32'h0000_0000);
        stall = 1'b0;
        mm_wr(1'b0, $urandom);
        wr_idle();
        drain();
        @(negedge sys_clk_i);
        {r_read, r_addr} = 2'b10;
        @(negedge sys_clk_i);
        chk_val(32'(r_wait), 32'h0000_0001);
        wr_idle();
        mm_rd(1'b1, 32'h0000_0000);
        wr_idle();
        for (int i = 0; i < 8; i++)
        begin
            sd[i] = $urandom;
            ss[i] = $urandom & 32'h00ff_ff7f;
            st_wr(sd[i], ss[i]);
        end
        wr_idle();
        for (int i = 0; i < 8; i++)
        begin
            mm_rd(1'b0, 32'(beat(sd[i])));
            mm_rd(1'b1, ss[i]);
        end
        wr_idle();
        repeat (2) @(negedge sys_clk_i);
        chk_val(32'(rdq.size()), 32'h0000_0000);
        end_of_test();
    end
endmodule
`default_nettype wire
